// File: bcs_pkg.sv
// constants, register map and types of the brake and current supervisor
package bcs_pkg;

  // register indices; byte address is four times the index
  localparam logic [13:0] IDX_LOW_SUPPLY = 14'h2035;
  localparam logic [13:0] IDX_RED_IDLE = 14'h2036;
  localparam logic [13:0] IDX_RED_SETTING = 14'h2037;
  localparam logic [13:0] IDX_CLOSE_IDLE = 14'h2040;
  localparam logic [13:0] IDX_SHUT_IDLE = 14'h2041;
  localparam logic [13:0] IDX_OPEN_DELAY = 14'h2042;
  localparam logic [13:0] IDX_START_DELAY = 14'h2043;
  localparam logic [13:0] IDX_PWM_FREQ = 14'h2044;
  localparam logic [13:0] IDX_PWM_DUTY = 14'h2045;
  localparam logic [13:0] IDX_FIELD_CUR = 14'h2048;
  localparam logic [13:0] IDX_TORQUE_CUR = 14'h2049;
  localparam logic [13:0] IDX_ALPHA_CUR = 14'h204A;
  localparam logic [13:0] IDX_BETA_CUR = 14'h204B;
  localparam logic [13:0] IDX_ACTUAL_CUR = 14'h204C;
  localparam logic [13:0] IDX_IRQ_STATUS = 14'h2050;
  localparam logic [13:0] IDX_IRQ_MASK = 14'h2051;
  localparam logic [13:0] IDX_MOTOR_CONFIG = 14'h2052;
  localparam logic [13:0] IDX_CONTROL = 14'h2053;
  localparam logic [13:0] IDX_RATED_CUR = 14'h2054;
  localparam logic [13:0] IDX_STATE = 14'h2055;

  // values after reset
  localparam logic [31:0] RST_LOW_SUPPLY = 32'h0000_2710;
  localparam logic [31:0] RST_RED_IDLE = 32'h0000_03E8;
  localparam logic [31:0] RST_RED_SETTING = 32'h0FFF_FFCE;
  localparam logic [31:0] RST_CLOSE_IDLE = 32'h0000_03E8;
  localparam logic [31:0] RST_SHUT_IDLE = 32'h0000_03E8;
  localparam logic [31:0] RST_OPEN_DELAY = 32'h0000_03E8;
  localparam logic [31:0] RST_START_DELAY = 32'h0000_0000;
  localparam logic [31:0] RST_PWM_FREQ = 32'h0000_0000;
  localparam logic [31:0] RST_PWM_DUTY = 32'h0000_0000;
  localparam logic [31:0] RST_RATED_CUR = 32'h0000_0834;

  // field positions
  localparam int CFG_REDUCTION_BIT = 3;
  localparam int CTL_POWER_BIT = 0;
  localparam int ST_UV_SET = 0;
  localparam int ST_UV_CLEAR = 1;
  localparam int ST_REDUCTION = 2;
  localparam int ST_OPERATION = 3;
  localparam int NUM_EVENTS = 4;

  // limits and scaling
  localparam logic [31:0] UV_HYST_MV = 32'h0000_05DC;
  localparam logic [31:0] PWM_MAX_HZ = 32'h0000_07D0;
  localparam logic [31:0] DUTY_MIN_PCT = 32'h0000_0002;
  localparam logic [31:0] DUTY_MAX_PCT = 32'h0000_0064;
  localparam logic [39:0] PCT_SCALE = 40'h00_0000_0064;
  localparam logic [47:0] SQRT2_Q15 = 48'h0000_0000_B505;

  // time base
  localparam int CLK_PERIOD_NS = 5;
  localparam int MS_PERIOD_NS = 1000000;
  localparam int MS_CYCLES = MS_PERIOD_NS / CLK_PERIOD_NS;
  localparam logic [39:0] CLK_HZ = 40'(1000000000 / CLK_PERIOD_NS);

  typedef enum logic [2:0] {
    SEQ_OFF = 3'b000,
    SEQ_POWER_ON = 3'b001,
    SEQ_BRAKE_OPEN = 3'b011,
    SEQ_OPERATION = 3'b010,
    SEQ_STOP_WAIT = 3'b110,
    SEQ_BRAKE_HOLD = 3'b111
  } bcs_seq_t;

endpackage : bcs_pkg

// File: bcs_pwm_if.sv
// brake pwm settings and output between the supervisor and the pwm generator
`timescale 1ns/1ps
interface bcs_pwm_if;
  logic [31:0] freqHz;
  logic [31:0] dutyPct;
  logic release_;
  logic pwmOut;
  modport ctrl (output freqHz, output dutyPct, output release_, input pwmOut);
  modport gen (input freqHz, input dutyPct, input release_, output pwmOut);
endinterface : bcs_pwm_if

// File: bcs_ms_tick.sv
// millisecond time base pulse
`timescale 1ns/1ps
module bcs_ms_tick #(
  parameter int CYCLES = 200000
) (
  input wire logic ref_clk,
  input wire logic srst,
  output logic tick
);
  typedef struct packed {
    logic [31:0] cnt;
    logic tick;
  } bcs_tick_st_t;

  bcs_tick_st_t s_q;
  bcs_tick_st_t s_d;

  always_comb begin
    s_d = s_q;
    s_d.tick = 1'b0;
    if (s_q.cnt == 32'(CYCLES - 1)) begin
      s_d.cnt = 32'h0000_0000;
      s_d.tick = 1'b1;
    end else begin
      s_d.cnt = s_q.cnt + 32'h0000_0001;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign tick = s_q.tick;
endmodule : bcs_ms_tick

// File: bcs_brake_pwm.sv
// software-style pwm for the holding brake output
`timescale 1ns/1ps
module bcs_brake_pwm
  import bcs_pkg::*;
(
  input wire logic ref_clk,
  input wire logic srst,
  bcs_pwm_if.gen pwm
);
  typedef struct packed {
    logic [39:0] cnt;
    logic out;
  } bcs_pwm_st_t;

  bcs_pwm_st_t s_q;
  bcs_pwm_st_t s_d;
  logic [39:0] period;

  always_comb begin
    s_d = s_q;
    period = (pwm.freqHz == 32'h0000_0000) ? 40'h00_0000_0001 : CLK_HZ / {8'h00, pwm.freqHz};
    if (s_q.cnt >= period - 40'h00_0000_0001) begin
      s_d.cnt = 40'h00_0000_0000;
    end else begin
      s_d.cnt = s_q.cnt + 40'h00_0000_0001;
    end
    if (!pwm.release_) begin
      s_d.out = 1'b0;
    end else if (pwm.freqHz == 32'h0000_0000 || pwm.dutyPct == 32'h0000_0000) begin
      s_d.out = 1'b1;
    end else begin
      // high for duty percent of each period
      s_d.out = (s_d.cnt * PCT_SCALE) < (period * {8'h00, pwm.dutyPct});
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign pwm.pwmOut = s_q.out;
endmodule : bcs_brake_pwm

// File: bcs_brake_current_supervisor.sv
// brake sequencing, undervoltage and standstill current supervisor with ahb-lite registers
//
// Chosen here: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
module bcs_brake_current_supervisor
  import bcs_pkg::*;
#(
  parameter int MS_CYCLES_P = MS_CYCLES
) (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic [31:0] supplyMv,
  input wire logic motorMoving,
  input wire logic signed [31:0] fieldCurrentRms,
  input wire logic signed [31:0] torqueCurrentRms,
  input wire logic signed [31:0] alphaCurrentRms,
  input wire logic signed [31:0] betaCurrentRms,
  input wire logic signed [31:0] actualCurrentRms,
  output logic driveEnable,
  output logic brakeOut,
  output logic operationEnabled,
  output logic undervoltageError,
  output logic reductionActive,
  output logic [31:0] currentSetpointMa,
  output logic irq
);

  typedef struct packed {
    logic [31:0] lowSupply;
    logic [31:0] redIdle;
    logic [31:0] redSetting;
    logic [31:0] closeIdle;
    logic [31:0] shutIdle;
    logic [31:0] openDelay;
    logic [31:0] startDelay;
    logic [31:0] pwmFreq;
    logic [31:0] pwmDuty;
    logic [31:0] ratedCur;
    logic [31:0] motorConfigWord;
    logic [31:0] control;
    logic [NUM_EVENTS-1:0] status;
    logic [NUM_EVENTS-1:0] mask;
    logic [31:0] fieldCurrent;
    logic [31:0] torqueCurrent;
    logic [31:0] alphaCurrent;
    logic [31:0] betaCurrent;
    logic [31:0] actualCurrent;
    logic uvErr;
    bcs_seq_t seq;
    logic [31:0] seqMs;
    logic [31:0] idleMs;
    logic redActive;
    logic [31:0] setpoint;
    logic driveEn;
    logic brakeRelease;
    logic opEnabled;
    logic irq;
    logic [31:0] rdata;
    logic readyOut;
    logic rdPend;
    logic wrPend;
    logic [13:0] addrIdx;
    logic addrOk;
  } bcs_state_t;

  bcs_state_t s_q;
  bcs_state_t s_d;
  logic msTick;
  logic addrPhase;
  logic [NUM_EVENTS-1:0] events;
  logic [31:0] reducedMa;

  bcs_pwm_if pwmBus ();

  bcs_ms_tick #(
    .CYCLES(MS_CYCLES_P)
  ) u_tick (
    .ref_clk(ref_clk),
    .srst(srst),
    .tick(msTick)
  );

  bcs_brake_pwm u_pwm (
    .ref_clk(ref_clk),
    .srst(srst),
    .pwm(pwmBus.gen)
  );

  assign pwmBus.freqHz = s_q.pwmFreq;
  assign pwmBus.dutyPct = s_q.pwmDuty;
  assign pwmBus.release_ = s_q.brakeRelease;

  function automatic logic [31:0] satInc(input logic [31:0] v);
    return (v == 32'hFFFF_FFFF) ? v : v + 32'h0000_0001;
  endfunction : satInc

  // rms to peak in fixed point
  function automatic logic [31:0] toPeak(input logic signed [31:0] rms);
    logic signed [47:0] prod;
    prod = 48'(rms) * $signed(SQRT2_Q15);
    return prod[46:15];
  endfunction : toPeak

  function automatic logic [31:0] reduction(input logic [31:0] setting, input logic [31:0] rated);
    logic signed [31:0] sv;
    logic [39:0] prod;
    sv = $signed(setting);
    prod = 40'h00_0000_0000;
    if (sv >= 0 && setting < rated) begin
      return setting;
    end else if (sv <= -1 && sv >= -100) begin
      prod = {8'h00, rated} * 40'(sv + 100);
      return 32'(prod / PCT_SCALE);
    end
    return rated;
  endfunction : reduction

  function automatic logic [31:0] readReg(input bcs_state_t s, input logic [13:0] idx);
    unique case (idx)
      IDX_LOW_SUPPLY: return s.lowSupply;
      IDX_RED_IDLE: return s.redIdle;
      IDX_RED_SETTING: return s.redSetting;
      IDX_CLOSE_IDLE: return s.closeIdle;
      IDX_SHUT_IDLE: return s.shutIdle;
      IDX_OPEN_DELAY: return s.openDelay;
      IDX_START_DELAY: return s.startDelay;
      IDX_PWM_FREQ: return s.pwmFreq;
      IDX_PWM_DUTY: return s.pwmDuty;
      IDX_FIELD_CUR: return s.fieldCurrent;
      IDX_TORQUE_CUR: return s.torqueCurrent;
      IDX_ALPHA_CUR: return s.alphaCurrent;
      IDX_BETA_CUR: return s.betaCurrent;
      IDX_ACTUAL_CUR: return s.actualCurrent;
      IDX_IRQ_STATUS: return {28'h000_0000, s.status};
      IDX_IRQ_MASK: return {28'h000_0000, s.mask};
      IDX_MOTOR_CONFIG: return s.motorConfigWord;
      IDX_CONTROL: return s.control;
      IDX_RATED_CUR: return s.ratedCur;
      IDX_STATE: return {24'h00_0000, s.redActive, s.opEnabled, s.brakeRelease, s.driveEn,
                         s.uvErr, s.seq};
      default: return 32'h0000_0000;
    endcase
  endfunction : readReg

  assign addrPhase = hsel && htrans[1] && hready;
  assign reducedMa = reduction(s_q.redSetting, s_q.ratedCur);

  always_comb begin
    s_d = s_q;
    events = '0;

    // bus: writes take their data phase with no wait, reads add one wait state
    s_d.wrPend = 1'b0;
    s_d.rdPend = 1'b0;
    s_d.readyOut = 1'b1;
    if (s_q.rdPend) begin
      s_d.rdata = s_q.addrOk ? readReg(s_q, s_q.addrIdx) : 32'h0000_0000;
    end
    if (s_q.wrPend && s_q.addrOk) begin
      unique case (s_q.addrIdx)
        IDX_LOW_SUPPLY: s_d.lowSupply = hwdata;
        IDX_RED_IDLE: s_d.redIdle = hwdata;
        IDX_RED_SETTING: s_d.redSetting = hwdata;
        IDX_CLOSE_IDLE: s_d.closeIdle = hwdata;
        IDX_SHUT_IDLE: s_d.shutIdle = hwdata;
        IDX_OPEN_DELAY: s_d.openDelay = hwdata;
        IDX_START_DELAY: s_d.startDelay = hwdata;
        IDX_PWM_FREQ: s_d.pwmFreq = (hwdata > PWM_MAX_HZ) ? PWM_MAX_HZ : hwdata;
        IDX_PWM_DUTY: begin
          if (hwdata == 32'h0000_0000 || (hwdata >= DUTY_MIN_PCT && hwdata <= DUTY_MAX_PCT)) begin
            s_d.pwmDuty = hwdata;
          end
        end
        IDX_IRQ_STATUS: s_d.status = s_q.status & ~hwdata[NUM_EVENTS-1:0];
        IDX_IRQ_MASK: s_d.mask = hwdata[NUM_EVENTS-1:0];
        IDX_MOTOR_CONFIG: s_d.motorConfigWord = hwdata;
        IDX_CONTROL: s_d.control = hwdata;
        IDX_RATED_CUR: s_d.ratedCur = hwdata;
        default: s_d.control = s_q.control;
      endcase
    end
    if (addrPhase) begin
      s_d.addrIdx = haddr[15:2];
      s_d.addrOk = (haddr[31:16] == 16'h0000) && (haddr[1:0] == 2'b00);
      s_d.wrPend = hwrite;
      s_d.rdPend = !hwrite;
      s_d.readyOut = hwrite;
    end

    // undervoltage with hysteresis, millivolt compare
    if (!s_q.uvErr && supplyMv < s_q.lowSupply) begin
      s_d.uvErr = 1'b1;
      events[ST_UV_SET] = 1'b1;
    end else if (s_q.uvErr && supplyMv > s_q.lowSupply + UV_HYST_MV) begin
      s_d.uvErr = 1'b0;
      events[ST_UV_CLEAR] = 1'b1;
    end

    // standstill idle timer and reduction
    if (motorMoving || !s_q.motorConfigWord[CFG_REDUCTION_BIT]) begin
      s_d.idleMs = 32'h0000_0000;
    end else if (msTick) begin
      s_d.idleMs = satInc(s_q.idleMs);
    end
    s_d.redActive = s_q.motorConfigWord[CFG_REDUCTION_BIT] && !motorMoving
                    && s_q.idleMs > s_q.redIdle;
    if (s_d.redActive && !s_q.redActive) begin
      events[ST_REDUCTION] = 1'b1;
    end
    s_d.setpoint = s_d.redActive ? reducedMa : s_q.ratedCur;

    // power and brake sequencer; compares are strict because the ms tick phase runs free,
    // so a delay of n ms never ends before n whole ms
    if (msTick) begin
      s_d.seqMs = satInc(s_q.seqMs);
    end
    unique case (s_q.seq)
      SEQ_OFF: begin
        if (s_q.control[CTL_POWER_BIT] && !s_q.uvErr) begin
          s_d.seq = SEQ_POWER_ON;
          s_d.driveEn = 1'b1;
          s_d.seqMs = 32'h0000_0000;
        end
      end
      SEQ_POWER_ON: begin
        if (!s_q.control[CTL_POWER_BIT]) begin
          s_d.seq = SEQ_STOP_WAIT;
          s_d.seqMs = 32'h0000_0000;
        end else if (s_q.seqMs > s_q.openDelay) begin
          s_d.seq = SEQ_BRAKE_OPEN;
          s_d.brakeRelease = 1'b1;
          s_d.seqMs = 32'h0000_0000;
        end
      end
      SEQ_BRAKE_OPEN: begin
        if (!s_q.control[CTL_POWER_BIT]) begin
          s_d.seq = SEQ_STOP_WAIT;
          s_d.seqMs = 32'h0000_0000;
        end else if (s_q.seqMs > s_q.startDelay) begin
          s_d.seq = SEQ_OPERATION;
          s_d.opEnabled = 1'b1;
          events[ST_OPERATION] = 1'b1;
        end
      end
      SEQ_OPERATION: begin
        if (!s_q.control[CTL_POWER_BIT]) begin
          s_d.seq = SEQ_STOP_WAIT;
          s_d.opEnabled = 1'b0;
          s_d.seqMs = 32'h0000_0000;
        end
      end
      SEQ_STOP_WAIT: begin
        if (motorMoving) begin
          s_d.seqMs = 32'h0000_0000;
        end else if (s_q.seqMs > s_q.closeIdle) begin
          s_d.seq = SEQ_BRAKE_HOLD;
          s_d.brakeRelease = 1'b0;
          s_d.seqMs = 32'h0000_0000;
        end
      end
      SEQ_BRAKE_HOLD: begin
        if (s_q.seqMs > s_q.shutIdle) begin
          s_d.seq = SEQ_OFF;
          s_d.driveEn = 1'b0;
        end
      end
      default: s_d.seq = SEQ_OFF;
    endcase

    // undervoltage overrides the sequence at once
    if (s_q.uvErr) begin
      s_d.seq = SEQ_OFF;
      s_d.driveEn = 1'b0;
      s_d.brakeRelease = 1'b0;
      s_d.opEnabled = 1'b0;
      events[ST_OPERATION] = 1'b0;
    end

    // measured currents as peak values
    s_d.fieldCurrent = toPeak(fieldCurrentRms);
    s_d.torqueCurrent = toPeak(torqueCurrentRms);
    s_d.alphaCurrent = toPeak(alphaCurrentRms);
    s_d.betaCurrent = toPeak(betaCurrentRms);
    s_d.actualCurrent = toPeak(actualCurrentRms);

    // sticky events: a new event wins over a clear in the same cycle
    s_d.status = s_d.status | events;
    s_d.irq = |(s_d.status & s_d.mask);
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      s_q <= '0;
      s_q.lowSupply <= RST_LOW_SUPPLY;
      s_q.redIdle <= RST_RED_IDLE;
      s_q.redSetting <= RST_RED_SETTING;
      s_q.closeIdle <= RST_CLOSE_IDLE;
      s_q.shutIdle <= RST_SHUT_IDLE;
      s_q.openDelay <= RST_OPEN_DELAY;
      s_q.startDelay <= RST_START_DELAY;
      s_q.pwmFreq <= RST_PWM_FREQ;
      s_q.pwmDuty <= RST_PWM_DUTY;
      s_q.ratedCur <= RST_RATED_CUR;
      s_q.seq <= SEQ_OFF;
      s_q.readyOut <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign hreadyout = s_q.readyOut;
  assign hresp = 1'b0;
  assign hrdata = s_q.rdata;
  assign driveEnable = s_q.driveEn;
  assign brakeOut = pwmBus.pwmOut;
  assign operationEnabled = s_q.opEnabled;
  assign undervoltageError = s_q.uvErr;
  assign reductionActive = s_q.redActive;
  assign currentSetpointMa = s_q.setpoint;
  assign irq = s_q.irq;

endmodule : bcs_brake_current_supervisor

// File: bcs_sva.sv
// assertions on the supervisor's top-level ports
`timescale 1ns/1ps
module bcs_sva
  import bcs_pkg::*;
#(
  parameter int MS_CYCLES_P = MS_CYCLES
) (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] supplyMv,
  input wire logic motorMoving,
  input wire logic driveEnable,
  input wire logic brakeOut,
  input wire logic operationEnabled,
  input wire logic undervoltageError,
  input wire logic reductionActive
);
  logic wrPend;
  logic [13:0] wrIdx;
  logic [31:0] thr;
  logic [31:0] idleMs;
  logic [31:0] still;
  // shadow of the threshold and idle time, snooped from bus writes
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      wrPend <= 1'b0;
      wrIdx <= 14'h0000;
      thr <= RST_LOW_SUPPLY;
      idleMs <= RST_RED_IDLE;
      still <= 32'h0000_0000;
    end else begin
      still <= motorMoving ? 32'h0000_0000 : still + 32'h0000_0001;
      if (hready) begin
        wrPend <= hsel && htrans[1] && hwrite;
        wrIdx <= haddr[15:2];
      end
      if (wrPend && hready && wrIdx == IDX_LOW_SUPPLY) thr <= hwdata;
      if (wrPend && hready && wrIdx == IDX_RED_IDLE) idleMs <= hwdata;
    end
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (srst);
  uv_set_a: assert property (supplyMv < thr |=> undervoltageError)
    else $error("undervoltage not raised");
  uv_clear_a: assert property (supplyMv > thr + UV_HYST_MV |=> !undervoltageError)
    else $error("undervoltage not cleared");
  uv_hold_a: assert property (undervoltageError && supplyMv >= thr
    && supplyMv <= thr + UV_HYST_MV |=> undervoltageError) else $error("hysteresis lost");
  drive_off_a: assert property (undervoltageError |=> !driveEnable && !operationEnabled)
    else $error("drive on during undervoltage");
  drive_first_a: assert property ($rose(driveEnable) |-> !brakeOut && !operationEnabled)
    else $error("brake released before current");
  brake_order_a: assert property ($rose(brakeOut) |-> driveEnable)
    else $error("brake released without current");
  op_order_a: assert property ($rose(operationEnabled) |-> driveEnable && !undervoltageError)
    else $error("operation without drive");
  shut_order_a: assert property ($fell(driveEnable) && !undervoltageError |-> !brakeOut)
    else $error("current off with brake open");
  red_still_a: assert property (motorMoving |=> !reductionActive)
    else $error("reduction while moving");
  red_idle_a: assert property ($rose(reductionActive) |->
    64'(still) + 64'(MS_CYCLES_P) >= 64'(idleMs) * 64'(MS_CYCLES_P)) else $error("reduction early");
  uv_c: cover property ($rose(undervoltageError));
  red_c: cover property ($rose(reductionActive));
  op_c: cover property ($rose(operationEnabled));
endmodule : bcs_sva

// File: bcs_plant.sv
// motor stage, brake and supply monitor as seen from the supervisor
`timescale 1ns/1ps
module bcs_plant (
  input wire logic driveEnable,
  input wire logic brakeOut,
  input wire logic [31:0] cmdSupply,
  input wire logic cmdMoving,
  input wire logic signed [31:0] cmdCur,
  output logic [31:0] supplyMv,
  output logic motorMoving,
  output logic signed [31:0] fieldCurrentRms,
  output logic signed [31:0] torqueCurrentRms,
  output logic signed [31:0] alphaCurrentRms,
  output logic signed [31:0] betaCurrentRms,
  output logic signed [31:0] actualCurrentRms
);
  logic signed [31:0] cur;
  // the rotor turns only with current on and the brake released
  assign motorMoving = cmdMoving && driveEnable && brakeOut;
  assign cur = driveEnable ? cmdCur : 32'sh0;
  assign supplyMv = cmdSupply;
  assign fieldCurrentRms = cur;
  assign torqueCurrentRms = -cur;
  assign alphaCurrentRms = cur >>> 1;
  assign betaCurrentRms = -(cur >>> 1);
  assign actualCurrentRms = cur;
endmodule : bcs_plant

// File: tb.sv
// self-checking bench of the brake and current supervisor
`timescale 1ns/1ps
`define CHK(a, e, m) begin cmpCount++; if ((a) !== (e)) begin numErrors++; \
  $display("MISMATCH %0t %s", $time, m); end end
module tb;
  import bcs_pkg::*;
  localparam int MSC = 20;
  logic ref_clk = 1'b0;
  logic srst = 1'b1;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic cmdMoving = 1'b0;
  logic [1:0] htrans = 2'b00;
  logic [31:0] haddr = 32'h0000_0000;
  logic [31:0] hwdata = 32'h0000_0000;
  logic [31:0] cmdSupply = 32'h0000_5DC0;
  logic signed [31:0] cmdCur = 32'sh0;
  logic hreadyout, hresp, driveEnable, brakeOut, operationEnabled;
  logic undervoltageError, reductionActive, irq, motorMoving;
  logic [31:0] hrdata, currentSetpointMa, supplyMv;
  logic signed [31:0] fieldCurrentRms, torqueCurrentRms, alphaCurrentRms;
  logic signed [31:0] betaCurrentRms, actualCurrentRms;
  int numErrors = 0;
  int cmpCount = 0;
  int cycles = 0;
  int c;
  bcs_brake_current_supervisor #(.MS_CYCLES_P(MSC)) DUT (.ref_clk, .srst, .hsel, .haddr,
    .htrans, .hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout), .hreadyout, .hresp,
    .hrdata, .supplyMv, .motorMoving, .fieldCurrentRms, .torqueCurrentRms, .alphaCurrentRms,
    .betaCurrentRms, .actualCurrentRms, .driveEnable, .brakeOut, .operationEnabled,
    .undervoltageError, .reductionActive, .currentSetpointMa, .irq);
  bcs_plant plant (.driveEnable, .brakeOut, .cmdSupply, .cmdMoving, .cmdCur, .supplyMv,
    .motorMoving, .fieldCurrentRms, .torqueCurrentRms, .alphaCurrentRms, .betaCurrentRms,
    .actualCurrentRms);
  always #2.5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      numErrors++;
      conclude();
    end
  end
  task automatic conclude;
    $display("errors %0d compares %0d", numErrors, cmpCount);
    if (numErrors == 0 && cmpCount > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : conclude
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : cyc
  task automatic bus(input logic w, input logic [13:0] i, inout logic [31:0] d);
    @(posedge ref_clk);
    hsel <= 1'b1;
    haddr <= {16'h0000, i, 2'b00};
    htrans <= 2'b10;
    hwrite <= w;
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    if (!w) d = hrdata;
  endtask : bus
  task automatic wr(input logic [13:0] i, input logic [31:0] d);
    bus(1'b1, i, d);
  endtask : wr
  task automatic rdChk(input logic [13:0] i, input logic [31:0] e, input string m);
    logic [31:0] v;
    v = 32'h0;
    bus(1'b0, i, v);
    `CHK(v, e, m)
    `CHK(hresp, 1'b0, "okay response")
  endtask : rdChk
  task automatic till(ref logic s, input logic v);
    c = 0;
    while (s !== v && c < 400) begin
      @(posedge ref_clk);
      c++;
    end
  endtask : till
  task automatic span(input int lo, input int hi, input string m);
    `CHK(c >= lo && c <= hi, 1'b1, m)
  endtask : span
  task automatic sup(input logic [31:0] v);
    @(posedge ref_clk);
    cmdSupply <= v;
    cyc(3);
  endtask : sup
  task automatic testRegs;
    logic [13:0] ix [9] = '{IDX_LOW_SUPPLY, IDX_RED_IDLE, IDX_RED_SETTING, IDX_CLOSE_IDLE,
      IDX_SHUT_IDLE, IDX_OPEN_DELAY, IDX_START_DELAY, IDX_PWM_FREQ, IDX_PWM_DUTY};
    logic [31:0] rv [9] = '{32'h2710, 32'h3E8, 32'h0FFF_FFCE, 32'h3E8, 32'h3E8, 32'h3E8,
      32'h0, 32'h0, 32'h0};
    logic [31:0] dw [6] = '{32'h32, 32'h1, 32'h65, 32'h2, 32'h64, 32'h0};
    logic [31:0] de [6] = '{32'h32, 32'h32, 32'h32, 32'h2, 32'h64, 32'h0};
    for (int k = 0; k < 9; k++) rdChk(ix[k], rv[k], "reset value");
    wr(IDX_FIELD_CUR, 32'h1234_5678);
    rdChk(IDX_FIELD_CUR, 32'h0, "read-only write");
    rdChk(14'h2060, 32'h0, "unmapped");
    wr(IDX_PWM_FREQ, 32'hBB8);
    rdChk(IDX_PWM_FREQ, 32'h7D0, "freq clamp");
    for (int k = 0; k < 6; k++) begin
      wr(IDX_PWM_DUTY, dw[k]);
      rdChk(IDX_PWM_DUTY, de[k], "duty accept");
    end
    wr(IDX_PWM_FREQ, 32'h0);
  endtask : testRegs
  task automatic testUv;
    sup(32'h270F);
    `CHK(undervoltageError, 1'b1, "uv set")
    sup(32'h2CEC);
    `CHK(undervoltageError, 1'b1, "uv hysteresis")
    sup(32'h2CED);
    `CHK(undervoltageError, 1'b0, "uv clear")
    `CHK(irq, 1'b0, "irq masked")
    rdChk(IDX_IRQ_STATUS, 32'h3, "uv events");
    wr(IDX_IRQ_MASK, 32'h1);
    cyc(2);
    `CHK(irq, 1'b1, "irq raised")
    wr(IDX_IRQ_STATUS, 32'h3);
    cyc(2);
    `CHK(irq, 1'b0, "irq cleared")
    sup(32'h5DC0);
    wr(IDX_LOW_SUPPLY, 32'h4E20);
    sup(32'h4E1F);
    `CHK(undervoltageError, 1'b1, "mv threshold")
    sup(32'h53FD);
    `CHK(undervoltageError, 1'b0, "mv clear")
    sup(32'h5DC0);
    wr(IDX_IRQ_STATUS, 32'hF);
  endtask : testUv
  task automatic testSeq;
    wr(IDX_OPEN_DELAY, 32'h2);
    wr(IDX_START_DELAY, 32'h1);
    wr(IDX_CLOSE_IDLE, 32'h2);
    wr(IDX_SHUT_IDLE, 32'h1);
    wr(IDX_CONTROL, 32'h1);
    till(driveEnable, 1'b1);
    `CHK(brakeOut, 1'b0, "current before brake")
    till(brakeOut, 1'b1);
    span(2 * MSC - 2, 3 * MSC + 2, "open delay");
    till(operationEnabled, 1'b1);
    span(MSC - 2, 2 * MSC + 2, "start delay");
    c = 0;
    repeat (50) begin
      @(posedge ref_clk);
      if (brakeOut !== 1'b1) c++;
    end
    `CHK(c, 0, "steady brake")
  endtask : testSeq
  task automatic testCurrents;
    logic [13:0] ix [5] = '{IDX_FIELD_CUR, IDX_TORQUE_CUR, IDX_ALPHA_CUR, IDX_BETA_CUR,
      IDX_ACTUAL_CUR};
    logic [31:0] ev [5] = '{32'h1_6A0A, 32'hFFFE_95F6, 32'hB505, 32'hFFFF_4AFB, 32'h1_6A0A};
    @(posedge ref_clk);
    cmdCur <= 32'sh0001_0000;
    cyc(3);
    for (int k = 0; k < 5; k++) rdChk(ix[k], ev[k], "peak current");
  endtask : testCurrents
  task automatic testReduce;
    logic [31:0] sv [5] = '{32'hFFFF_FF9C, 32'h1F4, 32'h834, 32'hFFFF_FFFF, 32'h0};
    logic [31:0] ev [5] = '{32'h0, 32'h1F4, 32'h834, 32'h81F, 32'h0};
    @(posedge ref_clk);
    cmdMoving <= 1'b1;
    wr(IDX_MOTOR_CONFIG, 32'h8);
    wr(IDX_RED_IDLE, 32'h2);
    wr(IDX_RED_SETTING, 32'hFFFF_FFC4);
    cyc(3 * MSC);
    `CHK(reductionActive, 1'b0, "moving blocks")
    @(posedge ref_clk);
    cmdMoving <= 1'b0;
    till(reductionActive, 1'b1);
    span(2 * MSC - 2, 3 * MSC + 2, "idle time");
    `CHK(currentSetpointMa, 32'h348, "percent setting")
    for (int k = 0; k < 5; k++) begin
      wr(IDX_RED_SETTING, sv[k]);
      cyc(3);
      `CHK(currentSetpointMa, ev[k], "reduced value")
    end
    @(posedge ref_clk);
    cmdMoving <= 1'b1;
    cyc(3);
    `CHK(reductionActive, 1'b0, "motion restarts")
    `CHK(currentSetpointMa, 32'h834, "rated current")
    wr(IDX_MOTOR_CONFIG, 32'h0);
    @(posedge ref_clk);
    cmdMoving <= 1'b0;
    cyc(4 * MSC);
    `CHK(reductionActive, 1'b0, "enable bit off")
  endtask : testReduce
  task automatic testStop;
    @(posedge ref_clk);
    cmdMoving <= 1'b1;
    wr(IDX_CONTROL, 32'h0);
    cyc(3);
    `CHK(operationEnabled, 1'b0, "stop request")
    cyc(5 * MSC);
    `CHK(brakeOut, 1'b1, "motion holds brake")
    @(posedge ref_clk);
    cmdMoving <= 1'b0;
    till(brakeOut, 1'b0);
    span(2 * MSC + 3, 3 * MSC + 3, "close idle");
    `CHK(driveEnable, 1'b1, "current after brake")
    till(driveEnable, 1'b0);
    span(MSC - 2, 2 * MSC + 2, "shutdown idle");
  endtask : testStop
  task automatic testUvRun;
    wr(IDX_CONTROL, 32'h1);
    till(operationEnabled, 1'b1);
    `CHK(operationEnabled, 1'b1, "operation reached")
    sup(32'h1388);
    `CHK(driveEnable, 1'b0, "uv drive off")
    `CHK(operationEnabled, 1'b0, "uv leaves operation")
    sup(32'h5DC0);
    `CHK(undervoltageError, 1'b0, "uv recovered")
  endtask : testUvRun
  initial begin
    repeat (10) @(posedge ref_clk);
    srst <= 1'b0;
    testRegs();
    testUv();
    testSeq();
    testCurrents();
    testReduce();
    testStop();
    testUvRun();
    conclude();
  end
endmodule : tb
bind bcs_brake_current_supervisor bcs_sva #(.MS_CYCLES_P(MS_CYCLES_P)) sva (.ref_clk, .srst,
  .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready, .supplyMv, .motorMoving, .driveEnable,
  .brakeOut, .operationEnabled, .undervoltageError, .reductionActive);
